// ==== core/ifr_flag_status.sv ====
// Reset-cause and interrupt flag status block with Wishbone registers
// Summary of operation
// - Brown-out reset flag reads one after a brown-out reset, else zero.
// - Power-on reset flag reads one after a power-on reset, else zero.
// - Software can set or clear each reset-cause bit independently.
// - Software setting a reset-cause bit never causes a device reset.
// - Watchdog fuse at one keeps the watchdog running; soft enable ignored.
// - Flags set on source request, reset to zero, read one until cleared.
// - Capture channel 2 flag sits at bit 5 of flag status register 0.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "ifr_map.svh"
module ifr_flag_status
    import ifr_pkg::*;
(
    input  wire logic        clk,              // System clock, 100 MHz
    input  wire logic        reset_n,          // Async reset, active low
    input  wire logic        powerOnEvent,     // Power-on reset seen, level
    input  wire logic        brownoutEvent,    // Brown-out reset seen, level
    input  wire logic        watchdogFuse,     // Watchdog fuse, 1 = unprogrammed
    input  wire logic        converterDone,    // Converter request
    input  wire logic        serialTx,         // Serial transmit request
    input  wire logic        serialRx,         // Serial receive request
    input  wire logic        spiEvent,         // SPI event request
    input  wire logic        spiFault,         // SPI fault request
    input  wire logic        timer3Req,        // Timer 3 request
    input  wire logic        timer2Req,        // Timer 2 request
    input  wire logic        compare2Req,      // Compare 2 request
    input  wire logic        capture2Req,      // Capture 2 request
    input  wire logic        timer1Req,        // Timer 1 request
    input  wire logic        compare1Req,      // Compare 1 request
    input  wire logic        capture1Req,      // Capture 1 request
    input  wire logic        external0Req,     // External 0 request
    input  wire logic        wb_cyc_i,         // Wishbone cycle
    input  wire logic        wb_stb_i,         // Wishbone strobe
    input  wire logic        wb_we_i,          // Wishbone write enable
    input  wire logic [4:0]  wb_adr_i,         // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,         // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,         // Wishbone write data
    output logic      [31:0] wb_dat_o,         // Wishbone read data
    output logic             wb_ack_o,         // Wishbone ack
    output logic             watchdogRun,      // Watchdog enabled
    output logic             irq               // Interrupt, active high level
);
    ifr_word_type resetCause;
    ifr_word_type flagStatus0;
    logic [1:0]   irqStatus;
    logic [1:0]   irqMask;
    logic         watchdogSoftEnable;
    logic         accept;
    logic         ackPulse;
    logic         wrStb;
    logic [15:0]  reqLevel;
    logic [15:0]  reqPulse;
    logic [1:0]   causePulse;
    logic [15:0]  wrMask;
    logic [15:0]  next_flag;
    logic [15:0]  next_cause;
    logic [1:0]   event_now;
    logic         wrCause;
    logic         wrFlag;
    logic         wrIrqStat;
    logic         wrIrqMask;
    logic         wrWdog;

    // Places byte-enable lanes 0 and 1 into a 16-bit write mask; lanes 2 and 3 are ignored
    function automatic logic [15:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    // Source vector laid out as the register so one edge detector serves all
    assign reqLevel = {
        2'b00,          // Bits 15:14 have no source
        converterDone,  // Bit 13
        serialTx,       // Bit 12
        serialRx,       // Bit 11
        spiEvent,       // Bit 10
        spiFault,       // Bit 9
        timer3Req,      // Bit 8
        timer2Req,      // Bit 7
        compare2Req,    // Bit 6
        capture2Req,    // Bit 5
        1'b0,           // Bit 4 has no source
        timer1Req,      // Bit 3
        compare1Req,    // Bit 2
        capture1Req,    // Bit 1
        external0Req    // Bit 0
    };

    ifr_edge_set #(.WIDTH(16)) u_req_edge (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (reqLevel),
        .pulse   (reqPulse)
    );

    ifr_edge_set #(.WIDTH(2)) u_cause_edge (
        .clk     (clk),
        .reset_n (reset_n),
        .level   ({brownoutEvent, powerOnEvent}),
        .pulse   (causePulse)
    );

    ifr_wb_slave u_bus (
        .clk      (clk),
        .reset_n  (reset_n),
        .cyc      (wb_cyc_i),
        .stb      (wb_stb_i),
        .ackPulse (ackPulse),
        .accept   (accept)
    );

    assign wrStb  = accept && wb_we_i;
    assign wrMask = lane_mask(wb_sel_i);

    // One decode per register, shared by the write paths and the checks
    assign wrCause   = wrStb && wb_adr_i == `IFR_OFF_RESET_CAUSE;
    assign wrFlag    = wrStb && wb_adr_i == `IFR_OFF_FLAG_STATUS0;
    assign wrIrqStat = wrStb && wb_adr_i == `IFR_OFF_IRQ_STATUS;
    assign wrIrqMask = wrStb && wb_adr_i == `IFR_OFF_IRQ_MASK;
    assign wrWdog    = wrStb && wb_adr_i == `IFR_OFF_WDOG_CTRL;
    assign wb_ack_o  = ackPulse;

    // Hardware sets win over a software clear in the same cycle
    always_comb begin
        next_flag = flagStatus0;
        if (wrFlag) begin
            next_flag = (flagStatus0 & ~wrMask) | (wb_dat_i[15:0] & wrMask);
        end
        next_flag = (next_flag | reqPulse) & `IFR_FLAG_MASK;
    end

    always_comb begin
        next_cause = resetCause;
        if (wrCause) begin
            next_cause = (resetCause & ~wrMask) | (wb_dat_i[15:0] & wrMask);
        end
        next_cause[`IFR_BIT_POWERON]  = next_cause[`IFR_BIT_POWERON] | causePulse[0];
        next_cause[`IFR_BIT_BROWNOUT] = next_cause[`IFR_BIT_BROWNOUT] | causePulse[1];
        next_cause = next_cause & `IFR_CAUSE_MASK;
    end

    // Cause bits only store; nothing here feeds any reset path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resetCause <= 16'h0000;
        end else begin
            resetCause <= next_cause;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flagStatus0 <= `IFR_FLAG_RESET;
        end else begin
            flagStatus0 <= next_flag;
        end
    end

    assign event_now = {|causePulse, |reqPulse};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus <= 2'h0;
        end else if (wrIrqStat && wb_sel_i[0]) begin
            irqStatus <= (irqStatus & ~wb_dat_i[1:0]) | event_now;
        end else begin
            irqStatus <= irqStatus | event_now;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMask <= 2'h0;
        end else if (wrIrqMask && wb_sel_i[0]) begin
            irqMask <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdogSoftEnable <= 1'b0;
        end else if (wrWdog && wb_sel_i[0]) begin
            watchdogSoftEnable <= wb_dat_i[0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdogRun <= 1'b0;
            irq         <= 1'b0;
        end else begin
            watchdogRun <= watchdogFuse | watchdogSoftEnable;
            irq         <= |(irqStatus & irqMask);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_dat_o <= 32'h0000_0000;
            if (accept && !wb_we_i) begin
                case (wb_adr_i)
                    `IFR_OFF_RESET_CAUSE:  wb_dat_o <= {16'h0000, resetCause};
                    `IFR_OFF_FLAG_STATUS0: wb_dat_o <= {16'h0000, flagStatus0};
                    `IFR_OFF_IRQ_STATUS:   wb_dat_o <= {30'h0, irqStatus};
                    `IFR_OFF_IRQ_MASK:     wb_dat_o <= {30'h0, irqMask};
                    `IFR_OFF_WDOG_CTRL:    wb_dat_o <= {31'h0, watchdogSoftEnable};
                    default:               wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Status checks, plus ack and read-data checks; the one-cycle ack is checked inside the slave
    brownoutSet_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(brownoutEvent) |=> resetCause[`IFR_BIT_BROWNOUT])
        else $error("brownout cause not latched");
    poweronSet_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(powerOnEvent) |=> resetCause[`IFR_BIT_POWERON])
        else $error("power-on cause not latched");
    causeUnused_a: assert property (@(posedge clk) disable iff (!reset_n)
        resetCause[15:2] == 14'h0000)
        else $error("unused cause bit set");
    causeWrite_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrCause && wb_sel_i[0] && !(|causePulse) |=> resetCause[1:0] == $past(wb_dat_i[1:0]))
        else $error("cause write lost");
    noSoftReset_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrCause |=> {irqMask, watchdogSoftEnable} == $past({irqMask, watchdogSoftEnable}))
        else $error("cause write disturbed other state");

    fuseWatchdog_a: assert property (@(posedge clk) disable iff (!reset_n)
        watchdogFuse |=> watchdogRun)
        else $error("fuse did not force watchdog");
    wdogFollow_a: assert property (@(posedge clk) disable iff (!reset_n)
        watchdogRun == $past(watchdogFuse | watchdogSoftEnable))
        else $error("watchdog run wrong");
    softWrite_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrWdog && wb_sel_i[0] |=> watchdogSoftEnable == $past(wb_dat_i[0]))
        else $error("soft enable write lost");

    flagSticky_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(timer2Req) |=> flagStatus0[7] ##1 (flagStatus0[7] || $past(wrFlag)))
        else $error("flag not sticky");
    flagClear_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrFlag && wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == 16'h0000 && !(|reqPulse)
        |=> flagStatus0 == 16'h0000)
        else $error("flag clear lost");
    capture2Pos_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(capture2Req) |=> flagStatus0[5])
        else $error("capture2 flag misplaced");
    timer1Pos_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(timer1Req) |=> flagStatus0[3])
        else $error("timer1 flag misplaced");
    timer1Write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrFlag && wb_sel_i[0] && !reqPulse[3] |=> flagStatus0[3] == $past(wb_dat_i[3]))
        else $error("timer1 flag write lost");
    zeroBits_a: assert property (@(posedge clk) disable iff (!reset_n)
        flagStatus0[15:14] == 2'b00 && !flagStatus0[4])
        else $error("unused flag bit set");
    converterPos_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(converterDone) |=> flagStatus0[13])
        else $error("converter flag misplaced");
    spiFaultPos_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(spiFault) |=> flagStatus0[9])
        else $error("spi fault flag misplaced");
    external0Pos_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(external0Req) |=> flagStatus0[0])
        else $error("external0 flag misplaced");

    statusSet_a: assert property (@(posedge clk) disable iff (!reset_n)
        |reqPulse |=> irqStatus[0])
        else $error("flag event not pending");
    causeStatus_a: assert property (@(posedge clk) disable iff (!reset_n)
        |causePulse |=> irqStatus[1])
        else $error("cause event not pending");
    statusClear_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrIrqStat && wb_sel_i[0] && wb_dat_i[1:0] == 2'b11 && !(|event_now)
        |=> irqStatus == 2'b00)
        else $error("pending clear lost");
    maskWrite_a: assert property (@(posedge clk) disable iff (!reset_n)
        wrIrqMask && wb_sel_i[0] |=> irqMask == $past(wb_dat_i[1:0]))
        else $error("mask write lost");
    irqLevel_a: assert property (@(posedge clk) disable iff (!reset_n)
        |(irqStatus & irqMask) |=> irq)
        else $error("irq missing");
    irqQuiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(|(irqStatus & irqMask)) |=> !irq)
        else $error("irq without cause");

    ackAnswer_a: assert property (@(posedge clk) disable iff (!reset_n)
        accept |=> wb_ack_o)
        else $error("ack missing");
    readUpper_a: assert property (@(posedge clk) disable iff (!reset_n)
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data set");

    readCover_c: cover property (@(posedge clk) accept && !wb_we_i ##1 wb_ack_o);
    writeCover_c: cover property (@(posedge clk) wrStb ##1 wb_ack_o);
    irqCover_c: cover property (@(posedge clk) $rose(irq));
    flagClearCover_c: cover property (@(posedge clk) wrFlag ##1 flagStatus0 == 16'h0000);
    fuseCover_c: cover property (@(posedge clk) $rose(watchdogFuse) ##1 watchdogRun);
endmodule : ifr_flag_status

// ==== core/ifr_map.svh ====
// Register offsets, field positions, reset values and counts for the flag block
`ifndef IFR_MAP_SVH
`define IFR_MAP_SVH
`define IFR_OFF_RESET_CAUSE   5'h00
`define IFR_OFF_FLAG_STATUS0  5'h04
`define IFR_OFF_IRQ_STATUS    5'h08
`define IFR_OFF_IRQ_MASK      5'h0c
`define IFR_OFF_WDOG_CTRL     5'h10
`define IFR_BIT_POWERON       0
`define IFR_BIT_BROWNOUT      1
`define IFR_CAUSE_MASK        16'h0003
`define IFR_FLAG_MASK         16'h3fef
`define IFR_FLAG_RESET        16'h0000
`define IFR_EV_FLAGSET        0
`define IFR_EV_CAUSESET       1
`define IFR_EV_MASK           2'h3
`define IFR_STRETCH_CYCLES    2
`endif

// ==== core/ifr_pkg.sv ====
// Types shared by the flag block
package ifr_pkg;
    typedef enum logic [1:0] {
        IFR_IDLE = 2'b00,
        IFR_ACK  = 2'b01,
        IFR_DONE = 2'b11
    } ifr_bus_state_type;
    typedef logic [15:0] ifr_word_type;
endpackage : ifr_pkg

// ==== core/ifr_edge_set.sv ====
// Turns a source request level into set pulses (rising edge) for a flag vector
`timescale 1ns/100ps
module ifr_edge_set
    import ifr_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,      // System clock
    input  wire logic             reset_n,  // Async reset, active low
    input  wire logic [WIDTH-1:0] level,    // Raw request levels
    output logic      [WIDTH-1:0] pulse     // One-cycle set pulses
);
    logic [WIDTH-1:0] prev;

    if (WIDTH < 1) begin : g_width_check
        $error("WIDTH must be positive");
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev <= '0;
        end else begin
            prev <= level;
        end
    end

    assign pulse = level & ~prev;
endmodule : ifr_edge_set

// ==== core/ifr_wb_slave.sv ====
// Classic Wishbone slave front end: one ack per access, one wait state
`timescale 1ns/100ps
module ifr_wb_slave
    import ifr_pkg::*;
(
    input  wire logic        clk,       // System clock
    input  wire logic        reset_n,   // Async reset, active low
    input  wire logic        cyc,       // Bus cycle
    input  wire logic        stb,       // Strobe
    output logic             ackPulse,  // Ack, one cycle
    output logic             accept     // Access taken this cycle
);
    ifr_bus_state_type state;

    // Access is taken in IDLE only; DONE forces one gap so ack drops between accesses
    assign accept = (state == IFR_IDLE) && cyc && stb;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= IFR_IDLE;
        end else begin
            case (state)
                IFR_IDLE: state <= accept ? IFR_ACK : IFR_IDLE;
                IFR_ACK:  state <= IFR_DONE;
                IFR_DONE: state <= IFR_IDLE;
                default:  state <= IFR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ackPulse <= 1'b0;
        end else begin
            ackPulse <= accept;
        end
    end

    ackOnce_a: assert property (@(posedge clk) disable iff (!reset_n)
        ackPulse |=> !ackPulse) else $error("ack held two cycles");
endmodule : ifr_wb_slave

// ==== test/ifr_flag_status_tb_top.sv ====
// Self-checking bench for the reset-cause and interrupt flag block
`timescale 1ns/100ps
`include "ifr_map.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module ifr_flag_status_tb_top;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        fuse = 1'b0;
    logic        powerOn = 1'b0;
    logic        brownout = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [13:0] src = 14'h0;
    wire  [31:0] dout;
    wire         ack;
    wire         wdRun;
    wire         irq;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;

    always #5 clk = ~clk;

    // Source levels sit at their flag positions; position 4 has no source
    ifr_flag_status dut_u (
        .clk(clk), .reset_n(reset_n), .powerOnEvent(powerOn), .brownoutEvent(brownout),
        .watchdogFuse(fuse), .converterDone(src[13]), .serialTx(src[12]),
        .serialRx(src[11]), .spiEvent(src[10]), .spiFault(src[9]), .timer3Req(src[8]),
        .timer2Req(src[7]), .compare2Req(src[6]), .capture2Req(src[5]),
        .timer1Req(src[3]), .compare1Req(src[2]), .capture1Req(src[1]),
        .external0Req(src[0]), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
        .wb_ack_o(ack), .watchdogRun(wdRun), .irq(irq)
    );

    task automatic wrap_up;
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Ack and read data are both taken at the rising edge that sees ack high
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= {16'h0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic expect_rd(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0000);
        `CHK(rdat, e)
    endtask : expect_rd

    task automatic pulse_src(input int i);
        @(posedge clk);
        src <= 14'h0001 << i;
        @(posedge clk);
        src <= 14'h0000;
    endtask : pulse_src

    // Outputs are read mid-cycle, after the registered update has settled
    task automatic check_irq(input logic e);
        @(negedge clk);
        `CHK(irq, e)
    endtask : check_irq

    task automatic check_wd(input logic e);
        @(negedge clk);
        `CHK(wdRun, e)
    endtask : check_wd

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        expect_rd(`IFR_OFF_FLAG_STATUS0, 32'h0);
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h0);
        @(posedge clk);
        powerOn <= 1'b1;
        @(posedge clk);
        powerOn <= 1'b0;
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h1);
        @(posedge clk);
        brownout <= 1'b1;
        @(posedge clk);
        brownout <= 1'b0;
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h3);
        wr(`IFR_OFF_RESET_CAUSE, 16'h0002);
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h2);
        wr(`IFR_OFF_RESET_CAUSE, 16'h0001);
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h1);
        for (int i = 0; i < 14; i++) begin
            if (i != 4) begin
                pulse_src(i);
                expect_rd(`IFR_OFF_FLAG_STATUS0, 32'h1 << i);
                wr(`IFR_OFF_FLAG_STATUS0, 16'h0000);
                expect_rd(`IFR_OFF_FLAG_STATUS0, 32'h0);
            end
        end
        wr(`IFR_OFF_FLAG_STATUS0, 16'hffff);
        expect_rd(`IFR_OFF_FLAG_STATUS0, 32'h3fef);
        wr(`IFR_OFF_RESET_CAUSE, 16'h0003);
        expect_rd(`IFR_OFF_FLAG_STATUS0, 32'h3fef);
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h3);
        // Both event kinds have already fired, so status bits are pending
        wr(`IFR_OFF_IRQ_MASK, 16'h0001);
        check_irq(1'b1);
        wr(`IFR_OFF_IRQ_MASK, 16'h0000);
        check_irq(1'b0);
        wr(`IFR_OFF_IRQ_STATUS, 16'h0003);
        expect_rd(`IFR_OFF_IRQ_STATUS, 32'h0);
        wr(`IFR_OFF_IRQ_MASK, 16'h0003);
        check_irq(1'b0);
        pulse_src(3);
        expect_rd(`IFR_OFF_IRQ_STATUS, 32'h1);
        check_irq(1'b1);
        wr(`IFR_OFF_RESET_CAUSE, 16'h0003);
        expect_rd(`IFR_OFF_IRQ_MASK, 32'h3);
        expect_rd(5'h14, 32'h0);
        wr(5'h18, 16'hffff);
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h3);
        @(posedge clk);
        fuse <= 1'b1;
        wr(`IFR_OFF_WDOG_CTRL, 16'h0000);
        check_wd(1'b1);
        @(posedge clk);
        fuse <= 1'b0;
        wr(`IFR_OFF_WDOG_CTRL, 16'h0000);
        check_wd(1'b0);
        wr(`IFR_OFF_WDOG_CTRL, 16'h0001);
        check_wd(1'b1);
        // A second reset in mid-run must clear every stored bit again
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        expect_rd(`IFR_OFF_FLAG_STATUS0, 32'h0);
        expect_rd(`IFR_OFF_RESET_CAUSE, 32'h0);
        check_wd(1'b0);
        wrap_up();
    end
endmodule : ifr_flag_status_tb_top
